/* File: core/rrsd_core.sv */
/*
 * rrsd_core: executes return, rotate-through-carry and sleep instructions.
 * assumes one instruction word per cycle with instr_valid_in, a file
 * register read port that answers combinationally, and a wake input
 * from the surrounding sleep logic.
 */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1: return pops stack top into PC, two cycles
// RULE2: rotate right: carry into bit7, bit0 out
// RULE3: rotate left: carry into bit0, bit7 out
// RULE4: dest 0 writes W, 1 writes file
// RULE5: rotate left opcode 00 1101 d fffffff
// RULE6: seven-bit file address, one-bit destination
// RULE7: rotates take one word, one cycle
// RULE8: rotates change only carry flag
// RULE9: sleep clears watchdog, sets time-out, clears power-down
// RULE10: sleep stops main oscillator
// RULE11: rotate right opcode 00 1100 d fffffff
// RULE12: fixed opcodes for return and sleep
//////////////////////////////////////////////////////////////////////////////
module rrsd_core
    import rrsd_pkg::*;
#(
    parameter int PC_W = RRSD_PCW
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic instr_valid_in,
    input wire logic [RRSD_IW-1:0] instr_in,
    input wire logic [RRSD_DW-1:0] file_rdata_in,
    input wire logic [PC_W-1:0] stack_top_entry_in,
    input wire logic wake_in,
    output logic [RRSD_FW-1:0] file_addr_out,
    output logic [RRSD_DW-1:0] file_wdata_out,
    output logic file_we_out,
    output logic [RRSD_DW-1:0] w_reg_out,
    output logic carry_out,
    output logic [PC_W-1:0] pc_out,
    output logic pc_load_out,
    output logic stack_pop_out,
    output logic watchdog_counter_clr_out,
    output logic time_out_flag_n_out,
    output logic power_down_flag_n_out,
    output logic osc_run_out,
    output logic busy_out
);

    //////////////////////////////////////////////////////////////////////////
    // decode

    // shared compare of the six-bit rotate opcode field
    function automatic logic is_rotate(input logic [RRSD_IW-1:0] ins, input logic [5:0] opc);
        is_rotate = (ins[RRSD_OPC_HI:RRSD_OPC_LO] == opc);
    endfunction : is_rotate

    // whole-word compare for the opcodes that carry no operand
    function automatic logic is_fixed(
        input logic [RRSD_IW-1:0] ins,
        input logic [RRSD_IW-1:0] opc
    );
        is_fixed = (ins == opc);
    endfunction : is_fixed

    // the run state is the only one that takes instructions
    function automatic logic is_run(input rrsd_state_t s);
        is_run = (s == RRSD_ST_RUN);
    endfunction : is_run

    // wide enough for the return's cycle count
    localparam int RET_CNT_W = 2;

    rrsd_state_t state_q;
    rrsd_state_t state_d;
    logic [RRSD_DW-1:0] w_q;
    logic [RRSD_DW-1:0] w_d;
    logic carry_q;
    logic carry_d;
    logic [PC_W-1:0] pc_d;
    logic to_n_d;
    logic pd_n_d;
    logic [RET_CNT_W-1:0] flush_cnt_q;
    logic flush_done;

    logic accept;
    logic dec_rrf;
    logic dec_rlf;
    logic dec_rot;
    logic dec_ret;
    logic dec_slp;
    logic dest_file;
    logic [RRSD_FW-1:0] faddr;

    logic [RRSD_DW-1:0] rot_right;
    logic [RRSD_DW-1:0] rot_left;
    logic [RRSD_DW-1:0] rot_res;
    logic rot_carry;

    // refused words are dropped, nothing queues behind a busy core
    assign accept = instr_valid_in && is_run(state_q);
    assign dec_rrf = accept && is_rotate(instr_in, RRSD_OPC_RRF); // RULE11
    assign dec_rlf = accept && is_rotate(instr_in, RRSD_OPC_RLF); // RULE5
    assign dec_rot = dec_rrf || dec_rlf;
    assign dec_ret = accept && is_fixed(instr_in, RRSD_OPC_RETURN); // RULE12
    assign dec_slp = accept && is_fixed(instr_in, RRSD_OPC_SLEEP); // RULE12
    assign dest_file = instr_in[RRSD_DEST_BIT]; // RULE6
    assign faddr = instr_in[RRSD_FW-1:0]; // RULE6

    //////////////////////////////////////////////////////////////////////////
    // rotate datapath, combinational off the file read port

    // one lane per bit: each takes its neighbour, the end lanes take carry
    for (genvar i = 0; i < RRSD_DW; i++) begin : g_lane
        if (i == RRSD_DW - 1) begin : g_right_end
            assign rot_right[i] = carry_q; // RULE2
        end else begin : g_right_mid
            assign rot_right[i] = file_rdata_in[i+1]; // RULE2
        end
        if (i == 0) begin : g_left_end
            assign rot_left[i] = carry_q; // RULE3
        end else begin : g_left_mid
            assign rot_left[i] = file_rdata_in[i-1]; // RULE3
        end
    end

    always_comb begin
        rot_res = file_rdata_in;
        rot_carry = carry_q;
        if (dec_rrf) begin
            rot_res = rot_right; // RULE2
            rot_carry = file_rdata_in[0]; // RULE2
        end else if (dec_rlf) begin
            rot_res = rot_left; // RULE3
            rot_carry = file_rdata_in[RRSD_DW-1]; // RULE3
        end
    end

    // read address is combinational so the rotate finishes in its own cycle
    always_comb begin
        file_addr_out = faddr;
    end

    //////////////////////////////////////////////////////////////////////////
    // state: return spends a second cycle flushing, sleep holds until wake

    always_comb begin
        state_d = state_q;
        case (state_q)
            RRSD_ST_RUN: begin
                if (dec_ret) begin
                    state_d = RRSD_ST_FLUSH; // RULE1
                end else if (dec_slp) begin
                    state_d = RRSD_ST_SLEEP; // RULE10
                end
            end
            RRSD_ST_FLUSH: begin
                if (flush_done) begin
                    state_d = RRSD_ST_RUN; // RULE1
                end
            end
            RRSD_ST_SLEEP: begin
                if (wake_in) begin
                    state_d = RRSD_ST_RUN;
                end
            end
            default: begin
                state_d = RRSD_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_q <= RRSD_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // counts the cycles the return still owes after its accepting edge
    assign flush_done = (flush_cnt_q < RET_CNT_W'(2));

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            flush_cnt_q <= '0;
        end else if (dec_ret) begin
            flush_cnt_q <= RET_CNT_W'(RRSD_RETURN_CYCLES - 1); // RULE1
        end else if (flush_cnt_q != '0) begin
            flush_cnt_q <= flush_cnt_q - 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // next values of the held registers; each holds unless its instruction is taken

    always_comb begin
        w_d = w_q;
        carry_d = carry_q;
        if (dec_rot) begin
            carry_d = rot_carry; // RULE8
            if (!dest_file) begin
                w_d = rot_res; // RULE4
            end
        end
    end

    // the loaded pc stands until the next return
    always_comb begin
        pc_d = pc_out;
        if (dec_ret) begin
            pc_d = stack_top_entry_in; // RULE1
        end
    end

    // flags only move on sleep here
    always_comb begin
        to_n_d = time_out_flag_n_out;
        pd_n_d = power_down_flag_n_out;
        if (dec_slp) begin
            to_n_d = 1'b1; // RULE9
            pd_n_d = 1'b0; // RULE9
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // status outputs follow the next state so they line up with it

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= !is_run(state_d);
        end
    end

    // the oscillator stays stopped for the whole sleep state
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            osc_run_out <= 1'b1;
        end else begin
            osc_run_out <= (state_d != RRSD_ST_SLEEP); // RULE10
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // working register, carry and file write-back

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            w_q <= RRSD_W_RST;
        end else begin
            w_q <= w_d; // RULE4
        end
    end

    // only carry moves; zero and digit carry live outside this block
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            carry_q <= RRSD_CARRY_RST;
        end else begin
            carry_q <= carry_d; // RULE8
        end
    end

    // write strobe pulses for one cycle per rotate that targets the file
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            file_we_out <= 1'b0;
        end else begin
            file_we_out <= dec_rot && dest_file; // RULE4 RULE7
        end
    end

    // data registered beside the strobe so both land in one cycle
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            file_wdata_out <= '0;
        end else begin
            file_wdata_out <= rot_res;
        end
    end

    assign w_reg_out = w_q;
    assign carry_out = carry_q;

    //////////////////////////////////////////////////////////////////////////
    // return: pc load and stack pop, status untouched

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pc_out <= PC_W'(RRSD_PC_RST);
        end else begin
            pc_out <= pc_d; // RULE1
        end
    end

    // pop and load pulse together so the stack and pc stay in step
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pc_load_out <= 1'b0;
        end else begin
            pc_load_out <= dec_ret; // RULE1
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            stack_pop_out <= 1'b0;
        end else begin
            stack_pop_out <= dec_ret; // RULE1
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sleep: watchdog clear pulse and status flags

    // one-cycle clear covers counter and prescaler alike
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            watchdog_counter_clr_out <= 1'b0;
        end else begin
            watchdog_counter_clr_out <= dec_slp; // RULE9
        end
    end

    // other setters of these flags live outside this block
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            time_out_flag_n_out <= RRSD_TO_N_RST;
        end else begin
            time_out_flag_n_out <= to_n_d; // RULE9
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            power_down_flag_n_out <= RRSD_PD_N_RST;
        end else begin
            power_down_flag_n_out <= pd_n_d; // RULE9
        end
    end

endmodule : rrsd_core

/* File: core/rrsd_pkg.sv */
/*
 * rrsd_pkg: constants for the return / rotate / sleep execution block.
 * assumes a 14-bit instruction word and an 8-bit data path.
 */
package rrsd_pkg;

    localparam int RRSD_IW = 14;
    localparam int RRSD_DW = 8;
    localparam int RRSD_FW = 7;
    localparam int RRSD_PCW = 13;

    // opcode fields
    localparam int RRSD_OPC_HI = 13;
    localparam int RRSD_OPC_LO = 8;
    localparam int RRSD_DEST_BIT = 7;
    localparam logic [5:0] RRSD_OPC_RRF = 6'h0C;
    localparam logic [5:0] RRSD_OPC_RLF = 6'h0D;
    localparam logic [13:0] RRSD_OPC_RETURN = 14'h0008;
    localparam logic [13:0] RRSD_OPC_SLEEP = 14'h0063;

    // reset values
    localparam logic [7:0] RRSD_W_RST = 8'h00;
    localparam logic [12:0] RRSD_PC_RST = 13'h0000;
    localparam logic RRSD_CARRY_RST = 1'b0;
    localparam logic RRSD_TO_N_RST = 1'b1;
    localparam logic RRSD_PD_N_RST = 1'b1;

    // instruction cycle counts
    localparam int RRSD_RETURN_CYCLES = 2;
    localparam int RRSD_ROTATE_CYCLES = 1;

    typedef enum logic [2:0] {
        RRSD_ST_RUN = 3'b001,
        RRSD_ST_FLUSH = 3'b010,
        RRSD_ST_SLEEP = 3'b100
    } rrsd_state_t;

endpackage : rrsd_pkg

/* File: verif/rrsd_core_assertions.sv */
/* rrsd_core_chk: port-level assertions for rrsd_core.
   assumes the bind below and the synchronous active-low reset. */
`timescale 1ns/1ps
module rrsd_core_chk
    import rrsd_pkg::*;
#(parameter int PC_W = RRSD_PCW) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic instr_valid_in,
    input wire logic [RRSD_IW-1:0] instr_in,
    input wire logic [RRSD_DW-1:0] file_rdata_in,
    input wire logic [PC_W-1:0] stack_top_entry_in,
    input wire logic wake_in,
    input wire logic [RRSD_FW-1:0] file_addr_out,
    input wire logic file_we_out,
    input wire logic [RRSD_DW-1:0] w_reg_out,
    input wire logic carry_out,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic pc_load_out,
    input wire logic stack_pop_out,
    input wire logic watchdog_counter_clr_out,
    input wire logic time_out_flag_n_out,
    input wire logic power_down_flag_n_out,
    input wire logic osc_run_out,
    input wire logic busy_out
);
    // an instruction counts only when the core is not busy
    wire logic take = instr_valid_in && !busy_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_addr_follow: assert property (file_addr_out == instr_in[6:0])
        else $error("file address does not follow instruction");
    a_ret_pops: assert property (take && instr_in == RRSD_OPC_RETURN |=> pc_load_out
        && stack_pop_out && busy_out && pc_out == $past(stack_top_entry_in))
        else $error("return did not load stack top");
    a_ret_second: assert property (pc_load_out |=> !busy_out && !pc_load_out)
        else $error("return not two cycles");
    a_rrf_carry: assert property (take && instr_in[13:8] == RRSD_OPC_RRF |=>
        carry_out == $past(file_rdata_in[0]) && file_we_out == $past(instr_in[7]))
        else $error("rotate right carry or destination wrong");
    a_rlf_carry: assert property (take && instr_in[13:8] == RRSD_OPC_RLF |=>
        carry_out == $past(file_rdata_in[7]) && !busy_out)
        else $error("rotate left carry wrong");
    a_carry_kept: assert property (!(take && instr_in[13:9] == 5'h06) |=> $stable(carry_out))
        else $error("carry changed without rotate");
    a_w_kept: assert property (file_we_out |-> $stable(w_reg_out))
        else $error("working register changed on file write");
    a_sleep_enter: assert property (take && instr_in == RRSD_OPC_SLEEP |=>
        watchdog_counter_clr_out && time_out_flag_n_out && !power_down_flag_n_out
        && !osc_run_out && busy_out)
        else $error("sleep entry outputs wrong");
    a_sleep_stays: assert property (!osc_run_out && !wake_in |=> !osc_run_out)
        else $error("oscillator restarted without wake");
endmodule : rrsd_core_chk
bind rrsd_core rrsd_core_chk #(.PC_W(PC_W)) i_rrsd_core_chk (.clk_in, .rst_b_in,
    .instr_valid_in, .instr_in, .file_rdata_in, .stack_top_entry_in, .wake_in, .file_addr_out,
    .file_we_out, .w_reg_out, .carry_out, .pc_out, .pc_load_out, .stack_pop_out,
    .watchdog_counter_clr_out, .time_out_flag_n_out, .power_down_flag_n_out, .osc_run_out,
    .busy_out);

/* File: verif/rrsd_core_test.sv */
/* rrsd_core_test: directed bench for rrsd_core.
   assumes the core answers one cycle after an accepted instruction. */
`timescale 1ns/1ps
module rrsd_core_test;
    import rrsd_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic wake_in = 1'b0;
    logic [13:0] instr_in = 14'h0000;
    logic [7:0] file_rdata_in = 8'h00;
    logic [12:0] stack_top_entry_in = 13'h1ABC;
    logic [7:0] file_wdata_out, w_reg_out;
    logic [12:0] pc_out;
    logic [6:0] file_addr_out;
    logic file_we_out, carry_out, pc_load_out, stack_pop_out, watchdog_counter_clr_out;
    logic time_out_flag_n_out, power_down_flag_n_out, osc_run_out, busy_out;
    int error_cnt = 0;
    int check_count = 0;
    always #20 clk_in = ~clk_in;
    rrsd_core i_rrsd_core (.clk_in, .rst_b_in, .instr_valid_in, .instr_in, .file_rdata_in,
        .stack_top_entry_in, .wake_in, .file_addr_out, .file_wdata_out, .file_we_out,
        .w_reg_out, .carry_out, .pc_out, .pc_load_out, .stack_pop_out,
        .watchdog_counter_clr_out, .time_out_flag_n_out, .power_down_flag_n_out,
        .osc_run_out, .busy_out);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one-cycle issue; results are looked at just after the accepting edge
    task automatic exec(input logic [13:0] op, input logic [7:0] rd);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= op;
        file_rdata_in <= rd;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask : exec
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1;
        chk({pc_load_out, stack_pop_out, watchdog_counter_clr_out, time_out_flag_n_out,
            power_down_flag_n_out, osc_run_out, busy_out, carry_out, w_reg_out}, 16'h1C00);
        exec(14'h0C05, 8'hE6);
        chk({6'h00, file_we_out, carry_out, w_reg_out}, 16'h0073);
        exec(14'h0D85, 8'hE6);
        chk({6'h00, file_we_out, carry_out, w_reg_out}, 16'h0373);
        chk({8'h00, file_wdata_out}, 16'h00CC);
        exec(14'h0CFF, 8'h01);
        chk({file_wdata_out, 6'h00, file_we_out, carry_out}, 16'h8003);
        chk({9'h000, file_addr_out}, 16'h007F);
        exec(14'h0D00, 8'h00);
        chk({6'h00, file_we_out, carry_out, w_reg_out}, 16'h0001);
        exec(14'h0E00, 8'h55);
        chk({6'h00, busy_out, carry_out, w_reg_out}, 16'h0001);
        // return, with a rotate offered while it is still busy
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        instr_in <= RRSD_OPC_RETURN;
        @(posedge clk_in);
        instr_in <= 14'h0D00;
        #1;
        chk({pc_load_out, stack_pop_out, busy_out, pc_out}, {3'b111, 13'h1ABC});
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({7'h00, busy_out, w_reg_out}, 16'h0001);
        exec(RRSD_OPC_SLEEP, 8'h00);
        chk({watchdog_counter_clr_out, time_out_flag_n_out, power_down_flag_n_out,
            osc_run_out, busy_out, 11'h000}, 16'hC800);
        exec(14'h0D00, 8'hFF);
        chk({6'h00, osc_run_out, busy_out, w_reg_out}, 16'h0101);
        @(posedge clk_in);
        wake_in <= 1'b1;
        @(posedge clk_in);
        wake_in <= 1'b0;
        #1;
        chk({6'h00, osc_run_out, busy_out, w_reg_out}, 16'h0201);
        report_and_stop();
    end
endmodule : rrsd_core_test
